// *** common/dbs_params.svh ***
// Offsets, field positions, reset values and counts of the debug security block
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DBS_ADDR_W        8
`define DBS_OFS_MAILBOX   8'h00
`define DBS_OFS_STATUS    8'h04
`define DBS_OFS_PW0       8'h08
`define DBS_OFS_PW1       8'h0c
`define DBS_OFS_PW2       8'h10
`define DBS_OFS_PW3       8'h14
`define DBS_OFS_UNLOCK    8'h18

// ****************************************************************
// Boot config word zero fields
// ****************************************************************
`define DBS_CFG_MODE_LSB  0
`define DBS_CFG_MODE_MSB  1
`define DBS_CFG_LDR_DIS   2
`define DBS_CFG_PIN_LSB   3
`define DBS_CFG_PIN_MSB   4

// ****************************************************************
// Mailbox field and reset values
// ****************************************************************
`define DBS_MBOX_LSB      0
`define DBS_MBOX_MSB      2
`define DBS_PW_RST        32'h0000_0000
`define DBS_RDATA_RST     32'h0000_0000

// ****************************************************************
// Timing counts
// ****************************************************************
// Synchroniser latency plus one cycle margin
`define DBS_PIN_SETTLE    3'h5

`endif

// *** common/dbs_pkg.sv ***
// Types and decode helpers of the debug security block
package dbs_pkg;

  typedef enum logic [2:0] {
    DBS_CMD_NONE         = 3'h0,
    DBS_CMD_FACTORY_MAN  = 3'h1,
    DBS_CMD_FACTORY_AUTO = 3'h2,
    DBS_CMD_MASS_MAN     = 3'h3,
    DBS_CMD_MASS_AUTO    = 3'h4
  } dbs_cmd_e;

  typedef enum logic [1:0] {
    DBS_DBG_OFF  = 2'h0,
    DBS_DBG_OPEN = 2'h1,
    DBS_DBG_PW   = 2'h2,
    DBS_DBG_RSVD = 2'h3
  } dbs_dbg_e;

  typedef enum logic [6:0] {
    DBS_ST_RESET     = 7'h01,
    DBS_ST_MBOX      = 7'h02,
    DBS_ST_ERASE_MN  = 7'h04,
    DBS_ST_ERASE_CFG = 7'h08,
    DBS_ST_PIN       = 7'h10,
    DBS_ST_LOADER    = 7'h20,
    DBS_ST_APP       = 7'h40
  } dbs_state_e;

  function automatic logic dbs_is_factory(input dbs_cmd_e cmd);
    dbs_is_factory = (cmd == DBS_CMD_FACTORY_MAN) ||
                     (cmd == DBS_CMD_FACTORY_AUTO);
  endfunction

  // Unknown codes fold to no command
  function automatic dbs_cmd_e dbs_cmd_decode(input logic [2:0] raw);
    case (raw)
      3'h1:    dbs_cmd_decode = DBS_CMD_FACTORY_MAN;
      3'h2:    dbs_cmd_decode = DBS_CMD_FACTORY_AUTO;
      3'h3:    dbs_cmd_decode = DBS_CMD_MASS_MAN;
      3'h4:    dbs_cmd_decode = DBS_CMD_MASS_AUTO;
      default: dbs_cmd_decode = DBS_CMD_NONE;
    endcase
  endfunction

endpackage

// *** verilog/dbs_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module dbs_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Pins in, filtered levels out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_lvl
);

  logic [WIDTH-1:0] stg1_ff;
  logic [WIDTH-1:0] stg2_ff;
  logic [WIDTH-1:0] stg3_ff;
  logic [WIDTH-1:0] lvl_ff;
  logic [WIDTH-1:0] nxt_lvl;
  wire  [WIDTH-1:0] agree;

  // Stage one feeds stage two only
  assign agree   = ~(stg2_ff ^ stg3_ff);
  assign nxt_lvl = (agree & stg3_ff) | (~agree & lvl_ff);
  assign pin_lvl = lvl_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stg1_ff <= '0;
      stg2_ff <= '0;
      stg3_ff <= '0;
      lvl_ff  <= '0;
    end else begin
      stg1_ff <= pin_in;
      stg2_ff <= stg1_ff;
      stg3_ff <= stg2_ff;
      lvl_ff  <= nxt_lvl;
    end
  end

endmodule

`default_nettype wire

// *** verilog/dbs_core.sv ***
// Debug mailbox, unlock sequencing, debug gating and boot selection
// Summary of operation
// - A probe writes unlock commands into a mailbox read by the boot sequence.
// - Factory reset erases main flash and then restores the config region.
// - Mass erase erases main flash only and leaves the config region alone.
// - After reset a high boot invoke pin starts the boot loader, not the app.
// - Config can disable the boot loader and choose the invoke pin.
// - Debug is off, open, or open only after a matching 128-bit password.
// - Debug mode and password come from config word zero and password words.
// - New protection settings apply only after a power cycle.
// - Reprogramming main flash never erases the config region.
`timescale 1ns/10ps
`default_nettype none
`include "dbs_params.svh"

module dbs_core
  import dbs_pkg::*;
#(
  parameter int PIN_NUM = 4
) (
  // Clock and resets
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   pwr_on_b,
  // Register port
  input  wire logic [`DBS_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Config flash region contents
  input  wire logic [31:0]            boot_config_word_zero,
  input  wire logic [127:0]           debug_password_words,
  // Flash erase handshake
  output logic                        erase_main_req,
  output logic                        erase_cfg_req,
  input  wire logic                   flash_done,
  // Boot invoke pins
  input  wire logic [PIN_NUM-1:0]     boot_invoke_pin,
  // Boot and debug status
  output logic                        dbg_access_en,
  output logic                        boot_loader_run,
  output logic                        app_run,
  output logic                        pwr_cycle_needed
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dbs_state_e     state_ff;
  dbs_state_e     nxt_state;
  dbs_cmd_e       mbox_ff;
  dbs_cmd_e       nxt_mbox;
  dbs_cmd_e       act_cmd_ff;
  dbs_dbg_e       dbg_mode_ff;
  logic [127:0]   shadow_pw_ff;
  logic [31:0]    pw_entry_ff [4];
  logic           unlocked_ff;
  logic           pwr_fresh_ff;
  logic           pwr_cycle_ff;
  logic [2:0]     settle_ff;
  logic [31:0]    rdata_ff;
  logic [31:0]    nxt_rdata;
  logic [PIN_NUM-1:0] pin_lvl;

  wire            rst_all_b;
  wire            mbox_wr;
  wire            unlock_wr;
  wire [3:0]      pw_wr;
  wire [127:0]    pw_entry;
  wire [1:0]      cfg_mode_w;
  wire            ldr_dis;
  wire [1:0]      pin_sel;
  wire            invoke_lvl;
  wire            pin_ready;
  wire            mbox_take;
  wire            shadow_load;
  wire            erase_ack;
  wire [31:0]     status_w;

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign rst_all_b  = rst_b & pwr_on_b;
  assign mbox_wr    = reg_wr && (reg_addr == `DBS_OFS_MAILBOX);
  assign unlock_wr  = reg_wr && (reg_addr == `DBS_OFS_UNLOCK);
  assign pw_wr[0]   = reg_wr && (reg_addr == `DBS_OFS_PW0);
  assign pw_wr[1]   = reg_wr && (reg_addr == `DBS_OFS_PW1);
  assign pw_wr[2]   = reg_wr && (reg_addr == `DBS_OFS_PW2);
  assign pw_wr[3]   = reg_wr && (reg_addr == `DBS_OFS_PW3);
  assign pw_entry   = {pw_entry_ff[3], pw_entry_ff[2],
                       pw_entry_ff[1], pw_entry_ff[0]};

  assign cfg_mode_w = boot_config_word_zero[`DBS_CFG_MODE_MSB:
                                            `DBS_CFG_MODE_LSB];
  assign ldr_dis    = boot_config_word_zero[`DBS_CFG_LDR_DIS];
  assign pin_sel    = boot_config_word_zero[`DBS_CFG_PIN_MSB:
                                            `DBS_CFG_PIN_LSB];
  assign invoke_lvl = pin_lvl[pin_sel];
  assign pin_ready  = (settle_ff == `DBS_PIN_SETTLE);

  assign mbox_take  = (state_ff == DBS_ST_MBOX) && (mbox_ff != DBS_CMD_NONE);
  assign shadow_load = rst_all_b && pwr_fresh_ff && (state_ff == DBS_ST_RESET);
  assign erase_ack  = erase_cfg_req && flash_done;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  dbs_pin_sync #(
    .WIDTH   (PIN_NUM)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_all_b),
    .pin_in  (boot_invoke_pin),
    .pin_lvl (pin_lvl)
  );

  // ****************************************************************
  // Boot sequence
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DBS_ST_RESET: begin
        nxt_state = DBS_ST_MBOX;
      end
      DBS_ST_MBOX: begin
        if (mbox_ff != DBS_CMD_NONE) begin
          nxt_state = DBS_ST_ERASE_MN;
        end else begin
          nxt_state = DBS_ST_PIN;
        end
      end
      DBS_ST_ERASE_MN: begin
        if (flash_done) begin
          if (dbs_is_factory(act_cmd_ff)) begin
            nxt_state = DBS_ST_ERASE_CFG;
          end else begin
            nxt_state = DBS_ST_PIN;
          end
        end
      end
      DBS_ST_ERASE_CFG: begin
        if (flash_done) begin
          nxt_state = DBS_ST_PIN;
        end
      end
      DBS_ST_PIN: begin
        if (pin_ready) begin
          if (invoke_lvl && !ldr_dis) begin
            nxt_state = DBS_ST_LOADER;
          end else begin
            nxt_state = DBS_ST_APP;
          end
        end
      end
      DBS_ST_LOADER: nxt_state = DBS_ST_LOADER;
      DBS_ST_APP:    nxt_state = DBS_ST_APP;
      default:       nxt_state = DBS_ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_all_b) begin
      state_ff <= DBS_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settle count restarts with each visit to the pin state
  always_ff @(posedge ref_clk) begin
    if (!rst_all_b || state_ff != DBS_ST_PIN) begin
      settle_ff <= 3'h0;
    end else if (!pin_ready) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  // ****************************************************************
  // Mailbox
  // ****************************************************************
  // Survives warm reset so an auto command lives through the probe's reset
  always_comb begin
    nxt_mbox = mbox_ff;
    if (mbox_take) begin
      nxt_mbox = DBS_CMD_NONE;
    end
    if (mbox_wr) begin
      nxt_mbox = dbs_cmd_decode(reg_wdata[`DBS_MBOX_MSB:`DBS_MBOX_LSB]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!pwr_on_b) begin
      mbox_ff    <= DBS_CMD_NONE;
      act_cmd_ff <= DBS_CMD_NONE;
    end else begin
      mbox_ff <= nxt_mbox;
      if (mbox_take) begin
        act_cmd_ff <= mbox_ff;
      end else if (!rst_b) begin
        act_cmd_ff <= DBS_CMD_NONE;
      end
    end
  end

  assign erase_main_req = (state_ff == DBS_ST_ERASE_MN);
  // Config region is only touched by a factory command
  assign erase_cfg_req  = (state_ff == DBS_ST_ERASE_CFG);

  // ****************************************************************
  // Protection shadow, loaded only on power-up
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!pwr_on_b) begin
      pwr_fresh_ff <= 1'b1;
      pwr_cycle_ff <= 1'b0;
    end else begin
      if (shadow_load) begin
        pwr_fresh_ff <= 1'b0;
      end
      if (erase_ack) begin
        pwr_cycle_ff <= 1'b1;
      end
    end
  end

  // Warm reset keeps the old shadow; that is why reprogramming needs a
  // power cycle before the new protection bites
  always_ff @(posedge ref_clk) begin
    if (!pwr_on_b) begin
      dbg_mode_ff  <= DBS_DBG_OFF;
      shadow_pw_ff <= '0;
    end else if (shadow_load) begin
      dbg_mode_ff  <= dbs_dbg_e'(cfg_mode_w);
      shadow_pw_ff <= debug_password_words;
    end
  end

  // ****************************************************************
  // Password entry and unlock
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_all_b) begin
      for (int i = 0; i < 4; i++) begin
        pw_entry_ff[i] <= `DBS_PW_RST;
      end
      unlocked_ff <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pw_wr[i]) begin
          pw_entry_ff[i] <= reg_wdata;
        end
      end
      if (unlock_wr) begin
        unlocked_ff <= (pw_entry == shadow_pw_ff);
      end
    end
  end

  // Reserved mode code is treated as off, the safe side
  assign dbg_access_en = !pwr_cycle_ff &&
                         (state_ff == DBS_ST_LOADER ||
                          state_ff == DBS_ST_APP) &&
                         (dbg_mode_ff == DBS_DBG_OPEN ||
                          (dbg_mode_ff == DBS_DBG_PW && unlocked_ff));

  assign boot_loader_run  = (state_ff == DBS_ST_LOADER);
  assign app_run          = (state_ff == DBS_ST_APP);
  assign pwr_cycle_needed = pwr_cycle_ff;

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign status_w = {17'h0, pwr_cycle_ff, unlocked_ff, ldr_dis,
                     dbg_mode_ff, state_ff, act_cmd_ff};

  // Password words are write-only so a probe cannot read them back
  always_comb begin
    nxt_rdata = `DBS_RDATA_RST;
    if (reg_rd) begin
      case (reg_addr)
        `DBS_OFS_MAILBOX: nxt_rdata = {29'h0, mbox_ff};
        `DBS_OFS_STATUS:  nxt_rdata = status_w;
        default:          nxt_rdata = `DBS_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_all_b) begin
      rdata_ff <= `DBS_RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dbs_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_all_b);

  sequence s_main_done_factory;
    erase_main_req && flash_done && dbs_is_factory(act_cmd_ff);
  endsequence

  sequence s_main_done_mass;
    erase_main_req && flash_done && !dbs_is_factory(act_cmd_ff);
  endsequence

  sequence s_loader_pick;
    state_ff == DBS_ST_PIN && pin_ready && invoke_lvl && !ldr_dis;
  endsequence

  mbox_capture_a: assert property (
    mbox_take && !mbox_wr |=> act_cmd_ff == $past(mbox_ff) &&
                              mbox_ff == DBS_CMD_NONE)
    else $error("Mailbox command not taken by boot");

  factory_cfg_a: assert property (
    s_main_done_factory |=> erase_cfg_req && !erase_main_req)
    else $error("Factory reset skipped config restore");

  mass_main_a: assert property (
    s_main_done_mass |=> state_ff == DBS_ST_PIN ##0 !erase_cfg_req[*2])
    else $error("Mass erase touched config region");

  cfg_only_fr_a: assert property (
    erase_cfg_req |-> dbs_is_factory(act_cmd_ff))
    else $error("Config erase without factory command");

  loader_entry_a: assert property (
    s_loader_pick |=> boot_loader_run[*3] ##0 !app_run)
    else $error("Invoke pin did not start boot loader");

  loader_off_a: assert property (
    state_ff == DBS_ST_PIN && ldr_dis |=> !boot_loader_run)
    else $error("Disabled boot loader was entered");

  pw_lock_a: assert property (
    dbg_mode_ff != DBS_DBG_OPEN && !unlocked_ff |-> !dbg_access_en)
    else $error("Debug open without password match");

  shadow_load_a: assert property (
    shadow_load |=> dbg_mode_ff == dbs_dbg_e'($past(cfg_mode_w)) &&
                    shadow_pw_ff == $past(debug_password_words))
    else $error("Shadow not loaded from config region");

  shadow_hold_a: assert property (
    !pwr_fresh_ff |=> $stable(dbg_mode_ff) && $stable(shadow_pw_ff))
    else $error("Protection changed without power cycle");

  boot_order_a: assert property (
    mbox_take |=> state_ff == DBS_ST_ERASE_MN ##1 !app_run)
    else $error("Pending command not acted on first");

endmodule

`default_nettype wire

// *** tb/dbs_flash_model.sv ***
// Flash partner model: answers erase requests with a one-cycle done pulse
`timescale 1ns/10ps
`default_nettype none

module dbs_flash_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Erase handshake
  input  wire logic       erase_main_req,
  input  wire logic       erase_cfg_req,
  output logic            flash_done,
  // Answer delay in cycles, zero for a prompt flash
  input  wire logic [7:0] delay
);
  logic [7:0] cnt_ff;
  wire        req_any;

  assign req_any = erase_main_req | erase_cfg_req;

  // Counter restarts after each pulse so a config step gets its own wait
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flash_done || !req_any) begin
      flash_done <= 1'b0;
      cnt_ff     <= 8'h00;
    end else if (cnt_ff == delay) begin
      flash_done <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the debug security block
`timescale 1ns/10ps
`default_nettype none
`include "dbs_params.svh"

module tb;
  import dbs_pkg::*;
  logic         ref_clk, rst_b, pwr_on_b, reg_wr, reg_rd, rd_d;
  logic [7:0]   reg_addr, fdelay;
  logic [31:0]  reg_wdata, reg_rdata, cfg;
  logic [127:0] pw;
  logic         erase_main_req, erase_cfg_req, flash_done;
  logic [3:0]   pins;
  logic         dbg_access_en, boot_loader_run, app_run, pwr_cycle_needed;
  logic [31:0]  exp_q[$];
  logic [31:0]  msk_q[$];
  int           fails, n_tests, saw_main, saw_cfg;
  integer       seed;

  dbs_core #(.PIN_NUM(4)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .pwr_on_b(pwr_on_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_config_word_zero(cfg), .debug_password_words(pw),
    .erase_main_req(erase_main_req), .erase_cfg_req(erase_cfg_req),
    .flash_done(flash_done), .boot_invoke_pin(pins),
    .dbg_access_en(dbg_access_en), .boot_loader_run(boot_loader_run),
    .app_run(app_run), .pwr_cycle_needed(pwr_cycle_needed));

  dbs_flash_model flash (.ref_clk(ref_clk), .rst_b(rst_b),
    .erase_main_req(erase_main_req), .erase_cfg_req(erase_cfg_req),
    .flash_done(flash_done), .delay(fdelay));

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  task automatic chk32(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic chk1(string nm, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", nm, e, s);
    end
  endtask

  // ****************************************************************
  // Output watcher
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      chk32("rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
    end
    rd_d <= reg_rd;
    if (erase_main_req === 1'b1) saw_main++;
    if (erase_cfg_req === 1'b1) saw_cfg++;
    if (app_run === 1'b1 && (erase_main_req | erase_cfg_req) !== 1'b0) begin
      chk1("app_run during erase", 1'b0, app_run);
    end
  end

  // ****************************************************************
  // Register port and reset tasks
  // ****************************************************************
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Warm or power-on reset with new config and pin levels, then boot
  task automatic boot(logic pwr, logic [1:0] md, logic dis, logic [1:0] sel,
                      logic [3:0] pn);
    int i;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    if (pwr) pwr_on_b <= 1'b0;
    cfg  <= {27'($random(seed)), sel, dis, md};
    pins <= pn;
    repeat (5) @(posedge ref_clk);
    rst_b    <= 1'b1;
    pwr_on_b <= 1'b1;
    saw_main = 0;
    saw_cfg  = 0;
    i = 0;
    @(negedge ref_clk);
    while (app_run !== 1'b1 && boot_loader_run !== 1'b1 && i < 400) begin
      @(negedge ref_clk);
      i++;
    end
    chk1("boot finished", 1'b1, i < 400);
  endtask

  task automatic outs(logic ldr, logic dbg, logic pcn);
    @(negedge ref_clk);
    chk1("boot_loader_run", ldr, boot_loader_run);
    chk1("app_run", !ldr, app_run);
    chk1("dbg_access_en", dbg, dbg_access_en);
    chk1("pwr_cycle_needed", pcn, pwr_cycle_needed);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Generous bound of 40000 cycles: whole sequence needs under a thousand cycles
  initial begin
    #(50 * 40000);
    fails++;
    summarize();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [3:0]  pn;
    logic [31:0] ecfg;
    seed = 32'hba282d00;
    {rst_b, pwr_on_b, reg_wr, reg_rd} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    fdelay = 8'h00;
    pins = 4'h0;
    cfg = 32'h0000_0001;
    pw = {$random(seed), $random(seed), $random(seed), $random(seed)};
    boot(1'b1, 2'h1, 1'b0, 2'h0, 4'h0);
    outs(1'b0, 1'b1, 1'b0);
    rd(`DBS_OFS_STATUS, 32'h0000_0600, 32'h0000_5ff8);
    rd(8'h40, 32'h0000_0000, 32'hffff_ffff);
    rd(`DBS_OFS_PW0, 32'h0000_0000, 32'hffff_ffff);
    // Unknown command code must fold to no command
    wr(`DBS_OFS_MAILBOX, 32'h0000_0007);
    rd(`DBS_OFS_MAILBOX, 32'h0000_0000, 32'h0000_0007);
    // Link lost in a low-power mode: probe goes quiet, then reconnects
    repeat (40) @(posedge ref_clk);
    rd(`DBS_OFS_STATUS, 32'h0000_0600, 32'h0000_5ff8);
    // Every unlock code, prompt and slow flash in turn
    for (int c = 1; c <= 4; c++) begin
      @(posedge ref_clk);
      fdelay <= (c % 2 == 1) ? 8'h00 : 8'h14;
      wr(`DBS_OFS_MAILBOX, (32'($random(seed)) & 32'hffff_fff8) | 32'(c));
      rd(`DBS_OFS_MAILBOX, 32'(c), 32'h0000_0007);
      boot(1'b0, 2'h1, 1'b0, 2'h0, 4'h0);
      chk32("main erase cycles", 32'(fdelay) + 32'h2, 32'(saw_main));
      ecfg = (c <= 2) ? 32'(fdelay) + 32'h2 : 32'h0;
      chk32("cfg erase cycles", ecfg, 32'(saw_cfg));
      outs(1'b0, c > 2, c <= 2);
      boot(1'b1, 2'h1, 1'b0, 2'h0, 4'h0);
      chk32("erase after power cycle", 32'h0, 32'(saw_main));
      outs(1'b0, 1'b1, 1'b0);
    end
    // Invoke pin selection and loader disable
    for (int s = 0; s < 4; s++) begin
      pn = 4'($random(seed)) | (4'h1 << s);
      boot(1'b0, 2'h1, 1'b0, 2'(s), pn);
      outs(1'b1, 1'b1, 1'b0);
      boot(1'b0, 2'h1, 1'b0, 2'(s), pn & ~(4'h1 << s));
      outs(1'b0, 1'b1, 1'b0);
    end
    boot(1'b0, 2'h1, 1'b1, 2'h0, 4'hf);
    outs(1'b0, 1'b1, 1'b0);
    // Password mode: right entry opens, wrong entry closes
    boot(1'b1, 2'h2, 1'b0, 2'h0, 4'h0);
    outs(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) wr(`DBS_OFS_PW0 + 8'(4 * i), pw[32 * i +: 32]);
    wr(`DBS_OFS_UNLOCK, $random(seed));
    outs(1'b0, 1'b1, 1'b0);
    rd(`DBS_OFS_STATUS, 32'h0000_2800, 32'h0000_2c00);
    wr(`DBS_OFS_PW3, pw[127:96] ^ 32'h8000_0000);
    wr(`DBS_OFS_UNLOCK, $random(seed));
    outs(1'b0, 1'b0, 1'b0);
    // Locked part: the probe recovers with a factory reset, its first pick
    wr(`DBS_OFS_MAILBOX, 32'h0000_0002);
    boot(1'b0, 2'h2, 1'b0, 2'h0, 4'h0);
    chk32("recovery cfg erase", 32'(fdelay) + 32'h2, 32'(saw_cfg));
    outs(1'b0, 1'b0, 1'b1);
    boot(1'b1, 2'h2, 1'b0, 2'h0, 4'h0);
    outs(1'b0, 1'b0, 1'b0);
    // Mode change waits for a power cycle, every mode code
    for (int m = 0; m < 4; m++) begin
      boot(1'b0, 2'(m), 1'b0, 2'h0, 4'h0);
      // Warm boot still runs on the mode of the previous power-up
      outs(1'b0, m == 2, 1'b0);
      boot(1'b1, 2'(m), 1'b0, 2'h0, 4'h0);
      outs(1'b0, m == 1, 1'b0);
    end
    summarize();
  end
endmodule
`default_nettype wire
